// *** rtl/ifp_pkg.sv ***
// ifp_pkg: constants shared by the in-system flash programming front end
// assumes: byte-wide special function register space, 25 MHz core clock
package ifp_pkg;
    // register addresses
    localparam logic [7:0] ADDR_CHIP_CONTROL = 8'h9f;
    localparam logic [7:0] ADDR_TRIGGER      = 8'ha4;
    localparam logic [7:0] ADDR_TADDR_LOW    = 8'ha6;
    localparam logic [7:0] ADDR_TADDR_HIGH   = 8'ha7;
    localparam logic [7:0] ADDR_FLASH_DATA   = 8'hae;
    localparam logic [7:0] ADDR_OP_COMMAND   = 8'haf;
    localparam logic [7:0] ADDR_TIMED_ACCESS = 8'hc7;
    // chip control and trigger fields
    localparam int BIT_SOFT_RESET     = 7;
    localparam int BIT_FAULT          = 6;
    localparam int BIT_LOADER_UPDATE  = 5;
    localparam int BIT_BOOT_SELECT    = 1;
    localparam int BIT_PROG_ENABLE    = 0;
    localparam int BIT_TRIGGER        = 0;
    // operation command fields
    localparam int CMD_REGION_HI      = 7;
    localparam int CMD_REGION_LO      = 6;
    localparam int CMD_WRITE_CLASS    = 5;
    localparam int CMD_CHIP_ENABLE    = 4;
    localparam int CMD_OPCODE_HI      = 3;
    // reset values
    localparam logic [7:0] RST_TADDR     = 8'h00;
    localparam logic [7:0] RST_DATA      = 8'h00;
    localparam logic [7:0] RST_COMMAND   = 8'h30;
    // timed access unlock bytes and open window
    localparam logic [7:0] TA_KEY_FIRST  = 8'haa;
    localparam logic [7:0] TA_KEY_SECOND = 8'h55;
    localparam logic [2:0] TA_WINDOW_CYC = 3'h3;
    // destination regions
    localparam logic [1:0] REGION_APP    = 2'h0;
    localparam logic [1:0] REGION_LOADER = 2'h1;
    localparam logic [1:0] REGION_SETUP  = 2'h3;
    // operation codes
    localparam logic [3:0] OP_READ       = 4'h0;
    localparam logic [3:0] OP_PROGRAM    = 4'h1;
    localparam logic [3:0] OP_PAGE_ERASE = 4'h2;
    // page size 128 bytes: low address bits cleared for an erase
    localparam int PAGE_BYTES = 128;
    localparam int PAGE_BITS  = $clog2(PAGE_BYTES);
    // clock and oscillator figures
    localparam real CORE_CLK_MHZ = 25.0;
    localparam real RC_OSC_MHZ   = 22.1184;
    // sequencer states
    typedef enum logic [1:0] {
        IFP_IDLE  = 2'b00,
        IFP_ISSUE = 2'b01,
        IFP_WAIT  = 2'b10,
        IFP_DONE  = 2'b11
    } ifp_state_t;
endpackage : ifp_pkg

// *** rtl/ifp_flash_ctrl.sv ***
// ifp_flash_ctrl: register front end and sequencer for in-system flash programming
// assumes: core writes registers on a one-cycle strobe, flash macro answers with done pulse
`timescale 1ns/1ps

// How it works
// (RULE1) app code writing app flash: fault
// (RULE2) app code writing locked loader flash: fault
// (RULE3) app code touching setup bytes: fault
// (RULE4) loader code writing loader flash: fault
// (RULE5) out-of-range or external access: fault
// (RULE6) fault flag sticky until software clears
// (RULE7) loader update enable opens loader flash
// (RULE8) boot select write picks next boot
// (RULE9) boot select read shows last boot
// (RULE10) programming enable runs the RC oscillator
// (RULE11) software clears enable when finished
// (RULE12) command holds region, controls, opcode
// (RULE13) address is high byte, low byte
// (RULE14) software loads data before program
// (RULE15) read result lands in data register
// (RULE16) trigger write starts hardware sequence
// (RULE17) core held while operation runs
// (RULE18) trigger self-clears, always reads zero
// (RULE19) control and trigger need timed access
// (RULE20) unlock is 0xAA then 0x55
// (RULE21) triggers ignored while enable clear
// (RULE22) page erase aligned to 128 bytes
// (RULE23) soft reset request under timed access
module ifp_flash_ctrl #(
    parameter int APP_BYTES    = 16384, // application flash size
    parameter int LOADER_BYTES = 2048,  // loader flash size
    parameter int SETUP_BYTES  = 16     // setup byte area size
) (
    input  wire logic        core_clk,        // 25 MHz system clock
    input  wire logic        sys_rst,         // synchronous reset, high
    input  wire logic [7:0]  sfr_addr,        // register address
    input  wire logic        sfr_wr,          // write strobe
    input  wire logic [7:0]  sfr_wdata,       // write data
    input  wire logic        sfr_rd,          // read strobe
    output logic      [7:0]  sfr_rdata,       // read data, next cycle
    input  wire logic        code_in_loader,  // core fetching from loader flash
    input  wire logic        boot_strap,      // boot source in use at reset
    output logic             core_hold,       // stall program counter
    output logic             rc_osc_enable,   // internal RC oscillator run
    output logic             soft_reset_req,  // one-cycle soft reset pulse
    output logic             boot_next,       // boot source for next reset
    output logic             flash_req,       // one-cycle operation request
    output logic      [1:0]  flash_region,    // destination region
    output logic      [3:0]  flash_opcode,    // operation code
    output logic      [15:0] flash_addr,      // target address
    output logic      [7:0]  flash_wdata,     // byte to program
    input  wire logic        flash_done,      // operation finished pulse
    input  wire logic [7:0]  flash_rdata      // byte fetched from flash
);
    logic [7:0]  taddr_low;
    logic [7:0]  taddr_high;
    logic [7:0]  flash_data;
    logic [7:0]  op_command;
    logic        fault;
    logic        loader_update;
    logic        prog_enable;
    logic        booted_loader;
    logic        ta_armed;
    logic [2:0]  ta_window;
    ifp_pkg::ifp_state_t state;

    logic        wr_ctrl;
    logic        wr_trig;
    logic        ta_open;
    logic        start;
    logic        is_write;
    logic        illegal;
    logic        out_of_range;
    logic [1:0]  region;
    logic [3:0]  opcode;
    logic [15:0] target;

    // decode of the command fields and address
    assign region   = op_command[ifp_pkg::CMD_REGION_HI:ifp_pkg::CMD_REGION_LO]; // RULE12
    assign opcode   = op_command[ifp_pkg::CMD_OPCODE_HI:0];                      // RULE12
    assign is_write = op_command[ifp_pkg::CMD_WRITE_CLASS];                      // RULE12
    assign target   = {taddr_high, taddr_low};                                   // RULE13
    assign ta_open  = (ta_window != 3'h0);
    assign wr_ctrl  = sfr_wr && sfr_addr == ifp_pkg::ADDR_CHIP_CONTROL && ta_open; // RULE19
    assign wr_trig  = sfr_wr && sfr_addr == ifp_pkg::ADDR_TRIGGER && ta_open;      // RULE19
    // a trigger counts only with the function enabled and no operation in flight
    assign start    = wr_trig && sfr_wdata[ifp_pkg::BIT_TRIGGER] && prog_enable
                      && state == ifp_pkg::IFP_IDLE;                               // RULE16 RULE21

    // size check; region 2 has no memory behind it and counts as oversize
    always_comb begin
        case (region)
            ifp_pkg::REGION_APP:    out_of_range = 32'(target) >= APP_BYTES;    // RULE5
            ifp_pkg::REGION_LOADER: out_of_range = 32'(target) >= LOADER_BYTES; // RULE5
            ifp_pkg::REGION_SETUP:  out_of_range = 32'(target) >= SETUP_BYTES;  // RULE5
            default:                out_of_range = 1'b1;                         // RULE5
        endcase
    end

    // access table by where the code runs
    always_comb begin
        illegal = out_of_range;
        if (!code_in_loader) begin
            if (region == ifp_pkg::REGION_APP && is_write) begin
                illegal = 1'b1; // RULE1
            end
            if (region == ifp_pkg::REGION_LOADER && is_write && !loader_update) begin
                illegal = 1'b1; // RULE2 RULE7
            end
            if (region == ifp_pkg::REGION_SETUP) begin
                illegal = 1'b1; // RULE3
            end
        end else if (region == ifp_pkg::REGION_LOADER && is_write) begin
            illegal = 1'b1; // RULE4
        end
    end

    // timed access: 0xAA then 0x55 opens a short window for one protected write
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ta_armed  <= 1'b0;
            ta_window <= 3'h0;
        end else if (sfr_wr && sfr_addr == ifp_pkg::ADDR_TIMED_ACCESS) begin
            ta_armed  <= (sfr_wdata == ifp_pkg::TA_KEY_FIRST);                   // RULE20
            ta_window <= (ta_armed && sfr_wdata == ifp_pkg::TA_KEY_SECOND)
                         ? ifp_pkg::TA_WINDOW_CYC : 3'h0;                        // RULE20
        end else if (wr_ctrl || wr_trig) begin
            ta_armed  <= 1'b0;
            ta_window <= 3'h0; // window spent by the protected write
        end else if (ta_open) begin
            ta_window <= ta_window - 3'h1;
        end
    end

    // plain read/write registers; data register also catches read results
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            taddr_low  <= ifp_pkg::RST_TADDR;
            taddr_high <= ifp_pkg::RST_TADDR;
            op_command <= ifp_pkg::RST_COMMAND;
            flash_data <= ifp_pkg::RST_DATA;
        end else begin
            if (sfr_wr && sfr_addr == ifp_pkg::ADDR_TADDR_LOW) begin
                taddr_low <= sfr_wdata;
            end
            if (sfr_wr && sfr_addr == ifp_pkg::ADDR_TADDR_HIGH) begin
                taddr_high <= sfr_wdata;
            end
            if (sfr_wr && sfr_addr == ifp_pkg::ADDR_OP_COMMAND) begin
                op_command <= sfr_wdata;
            end
            // the core is stalled during the wait, so the two writers never meet
            if (state == ifp_pkg::IFP_WAIT && flash_done && !is_write) begin
                flash_data <= flash_rdata; // RULE15
            end else if (sfr_wr && sfr_addr == ifp_pkg::ADDR_FLASH_DATA) begin
                flash_data <= sfr_wdata;   // RULE14
            end
        end
    end

    // chip control bits; the fault set wins over a clear in the same cycle
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            fault         <= 1'b0;
            loader_update <= 1'b0;
            prog_enable   <= 1'b0;
        end else begin
            if (start && illegal) begin
                fault <= 1'b1; // RULE1 RULE2 RULE3 RULE4 RULE5 RULE6
            end else if (wr_ctrl && !sfr_wdata[ifp_pkg::BIT_FAULT]) begin
                fault <= 1'b0; // RULE6
            end
            if (wr_ctrl) begin
                loader_update <= sfr_wdata[ifp_pkg::BIT_LOADER_UPDATE]; // RULE7
                prog_enable   <= sfr_wdata[ifp_pkg::BIT_PROG_ENABLE];   // RULE21
            end
        end
    end

    // boot source: written value aims the next reset, read value is the last boot
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            booted_loader <= boot_strap; // RULE9
            boot_next     <= boot_strap;
        end else if (wr_ctrl) begin
            boot_next     <= sfr_wdata[ifp_pkg::BIT_BOOT_SELECT]; // RULE8
        end
    end

    // oscillator follows the enable; left running costs power until cleared
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rc_osc_enable  <= 1'b0;
            soft_reset_req <= 1'b0;
        end else begin
            rc_osc_enable  <= prog_enable;                                   // RULE10 RULE11
            soft_reset_req <= wr_ctrl && sfr_wdata[ifp_pkg::BIT_SOFT_RESET]; // RULE23
        end
    end

    // sequencer: an illegal request finishes at once with no flash access
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state        <= ifp_pkg::IFP_IDLE;
            core_hold    <= 1'b0;
            flash_req    <= 1'b0;
            flash_region <= 2'h0;
            flash_opcode <= 4'h0;
            flash_addr   <= 16'h0000;
            flash_wdata  <= 8'h00;
        end else begin
            flash_req <= 1'b0;
            case (state)
                ifp_pkg::IFP_IDLE: begin
                    if (start && !illegal) begin
                        state        <= ifp_pkg::IFP_ISSUE;
                        core_hold    <= 1'b1; // RULE17
                        flash_req    <= 1'b1; // RULE16
                        flash_region <= region;
                        flash_opcode <= opcode;
                        flash_wdata  <= flash_data;
                        flash_addr   <= (opcode == ifp_pkg::OP_PAGE_ERASE)
                            ? {target[15:ifp_pkg::PAGE_BITS], {ifp_pkg::PAGE_BITS{1'b0}}}
                            : target; // RULE22
                    end
                end
                ifp_pkg::IFP_ISSUE: begin
                    state <= ifp_pkg::IFP_WAIT;
                end
                ifp_pkg::IFP_WAIT: begin
                    if (flash_done) begin
                        state <= ifp_pkg::IFP_DONE;
                    end
                end
                ifp_pkg::IFP_DONE: begin
                    state     <= ifp_pkg::IFP_IDLE;
                    core_hold <= 1'b0; // RULE17 RULE18
                end
                default: begin
                    state     <= ifp_pkg::IFP_IDLE;
                    core_hold <= 1'b0;
                end
            endcase
        end
    end

    // registered read port; trigger, soft reset and reserved bits read zero
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            sfr_rdata <= 8'h00;
        end else if (sfr_rd) begin
            case (sfr_addr)
                ifp_pkg::ADDR_CHIP_CONTROL:
                    sfr_rdata <= {1'b0, fault, loader_update, 3'b000,
                                  booted_loader, prog_enable}; // RULE9
                ifp_pkg::ADDR_TADDR_LOW:  sfr_rdata <= taddr_low;
                ifp_pkg::ADDR_TADDR_HIGH: sfr_rdata <= taddr_high;
                ifp_pkg::ADDR_FLASH_DATA: sfr_rdata <= flash_data; // RULE15
                ifp_pkg::ADDR_OP_COMMAND: sfr_rdata <= op_command;
                default:                  sfr_rdata <= 8'h00;     // RULE18
            endcase
        end
    end

    // checks
    sequence s_issue;
        flash_req && core_hold;
    endsequence
    sequence s_finish;
        core_hold ##1 !core_hold;
    endsequence

    property p_fault_set;
        @(posedge core_clk) disable iff (sys_rst) start && illegal |=> fault;
    endproperty
    a_fault_set: assert property (p_fault_set) else $error("fault not set"); // RULE1

    property p_fault_sticky;
        @(posedge core_clk) disable iff (sys_rst) fault && !wr_ctrl |=> fault;
    endproperty
    a_fault_sticky: assert property (p_fault_sticky) else $error("fault dropped"); // RULE6

    property p_no_req_illegal;
        @(posedge core_clk) disable iff (sys_rst) start && illegal |=> !flash_req;
    endproperty
    a_no_req_illegal: assert property (p_no_req_illegal) else $error("bad access issued"); // RULE2

    property p_start_issue;
        @(posedge core_clk) disable iff (sys_rst) start && !illegal |=> s_issue;
    endproperty
    a_start_issue: assert property (p_start_issue) else $error("trigger lost"); // RULE16

    property p_hold_until_done;
        @(posedge core_clk) disable iff (sys_rst)
            state == ifp_pkg::IFP_WAIT && flash_done |=> s_finish;
    endproperty
    a_hold_until_done: assert property (p_hold_until_done) else $error("hold wrong"); // RULE17

    property p_hold_during_wait;
        @(posedge core_clk) disable iff (sys_rst) state == ifp_pkg::IFP_WAIT |-> core_hold;
    endproperty
    a_hold_during_wait: assert property (p_hold_during_wait) else $error("core ran"); // RULE17

    property p_no_trigger_disabled;
        @(posedge core_clk) disable iff (sys_rst) wr_trig && !prog_enable |=> !flash_req;
    endproperty
    a_no_trigger_disabled: assert property (p_no_trigger_disabled)
        else $error("trigger while disabled"); // RULE21

    property p_unlocked_only;
        @(posedge core_clk) disable iff (sys_rst)
            sfr_wr && sfr_addr == ifp_pkg::ADDR_TRIGGER && !ta_open |=> !flash_req;
    endproperty
    a_unlocked_only: assert property (p_unlocked_only) else $error("locked trigger ran"); // RULE19

    property p_erase_aligned;
        @(posedge core_clk) disable iff (sys_rst)
            flash_req && flash_opcode == ifp_pkg::OP_PAGE_ERASE
            |-> flash_addr[ifp_pkg::PAGE_BITS-1:0] == '0;
    endproperty
    a_erase_aligned: assert property (p_erase_aligned) else $error("erase misaligned"); // RULE22

    property p_osc_follows;
        @(posedge core_clk) disable iff (sys_rst) $rose(prog_enable) |=> rc_osc_enable;
    endproperty
    a_osc_follows: assert property (p_osc_follows) else $error("osc not started"); // RULE10

    property p_read_capture;
        @(posedge core_clk) disable iff (sys_rst)
            state == ifp_pkg::IFP_WAIT && flash_done && !is_write
            |=> flash_data == $past(flash_rdata);
    endproperty
    a_read_capture: assert property (p_read_capture) else $error("read byte lost"); // RULE15

    property p_soft_reset;
        @(posedge core_clk) disable iff (sys_rst)
            wr_ctrl && sfr_wdata[ifp_pkg::BIT_SOFT_RESET] |=> soft_reset_req ##1 !soft_reset_req;
    endproperty
    a_soft_reset: assert property (p_soft_reset) else $error("soft reset pulse wrong"); // RULE23
endmodule // ifp_flash_ctrl

// *** testbench/ifp_flash_model.sv ***
// ifp_flash_model: behavioural flash macro answering operation requests
// assumes: one request at a time, one-cycle request pulse on the core clock
`timescale 1ns/1ps
module ifp_flash_model (
    input  wire logic        core_clk,    // system clock
    input  wire logic        sys_rst,     // synchronous reset, high
    input  wire logic        flash_req,   // operation request pulse
    input  wire logic [15:0] flash_addr,  // target address
    output logic             flash_done,  // completion pulse
    output logic      [7:0]  flash_rdata  // fetched byte, valid with done
);
    logic [3:0] wait_cnt;  // cycles left in the running operation
    logic [7:0] len_seq;   // varies latency so prompt and slow answers both occur
    // answer 3..10 cycles after the request; data line scrambles outside done
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            wait_cnt    <= 4'h0;
            len_seq     <= 8'h5a;
            flash_done  <= 1'b0;
            flash_rdata <= 8'h00;
        end else begin
            flash_done  <= 1'b0;
            flash_rdata <= ~flash_rdata;
            if (flash_req) begin
                wait_cnt <= 4'h3 + {1'b0, len_seq[2:0]};
                len_seq  <= {len_seq[6:0], len_seq[7] ^ len_seq[5]};
            end else if (wait_cnt == 4'h1) begin
                wait_cnt    <= 4'h0;
                flash_done  <= 1'b1;
                flash_rdata <= flash_addr[7:0] ^ flash_addr[15:8] ^ 8'hc3;
            end else if (wait_cnt != 4'h0) begin
                wait_cnt <= wait_cnt - 4'h1;
            end
        end
    end
endmodule // ifp_flash_model

// *** testbench/test_inapp_flash_program_control.sv ***
// test_inapp_flash_program_control: self-checking bench for the flash front end
// assumes: flash macro modelled by ifp_flash_model, registers reached by sfr strobes
`timescale 1ns/1ps
module test_inapp_flash_program_control;
    logic        core_clk, sys_rst, sfr_wr, sfr_rd, code_in_loader, boot_strap;
    logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, flash_wdata, flash_rdata, r;
    logic        core_hold, rc_osc_enable, soft_reset_req, boot_next, flash_req, flash_done;
    logic [1:0]  flash_region;
    logic [3:0]  flash_opcode;
    logic [15:0] flash_addr;
    logic [31:0] seed = 32'h762a_6bf3;
    logic [31:0] rw;
    logic        ldu, en, bootw;
    int          error_cnt, n_checks, req_cnt, sr_cnt, i;
    logic [7:0]  ra [7] = '{8'ha6, 8'ha7, 8'hae, 8'haf, 8'ha4, 8'h9f, 8'h10};
    logic [7:0]  rv [7] = '{8'h00, 8'h00, 8'h00, 8'h30, 8'h00, 8'h02, 8'h00};

    ifp_flash_ctrl u_dut (.core_clk(core_clk), .sys_rst(sys_rst), .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
        .code_in_loader(code_in_loader), .boot_strap(boot_strap), .core_hold(core_hold),
        .rc_osc_enable(rc_osc_enable), .soft_reset_req(soft_reset_req),
        .boot_next(boot_next), .flash_req(flash_req), .flash_region(flash_region),
        .flash_opcode(flash_opcode), .flash_addr(flash_addr), .flash_wdata(flash_wdata),
        .flash_done(flash_done), .flash_rdata(flash_rdata));
    ifp_flash_model u_flash (.core_clk(core_clk), .sys_rst(sys_rst), .flash_req(flash_req),
        .flash_addr(flash_addr), .flash_done(flash_done), .flash_rdata(flash_rdata));

    // 25 MHz core clock
    always #20 core_clk = ~core_clk;
    // pulse counters, so one-cycle outputs are never missed by polling
    always @(posedge core_clk) begin
        if (flash_req === 1'b1) req_cnt++;
        if (soft_reset_req === 1'b1) sr_cnt++;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // chip control as written and as read back; booted source follows the strap input
    function automatic logic [7:0] ccw(input logic sr, input logic f);
        return {sr, f, ldu, 3'b000, bootw, en};
    endfunction
    function automatic logic [7:0] ccr(input logic f);
        return {1'b0, f, ldu, 3'b000, boot_strap, en};
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        sfr_addr  <= a;
        sfr_wdata <= d;
        sfr_wr    <= 1'b1;
        @(posedge core_clk);
        sfr_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        sfr_addr <= a;
        sfr_rd   <= 1'b1;
        @(posedge core_clk);
        sfr_rd <= 1'b0;
        @(posedge core_clk);
        #1 d = sfr_rdata;
    endtask
    // unlock then one protected write, spaced inside the open window
    task automatic pw(input logic [7:0] a, input logic [7:0] d);
        wr(ifp_pkg::ADDR_TIMED_ACCESS, ifp_pkg::TA_KEY_FIRST);
        wr(ifp_pkg::ADDR_TIMED_ACCESS, ifp_pkg::TA_KEY_SECOND);
        wr(a, d);
    endtask
    task automatic op(input logic [7:0] cmd, input logic [15:0] a, input logic ok,
                      input logic flt);
        logic [7:0]  fd;
        logic [15:0] ea;
        int          n;
        int          c0;
        fd = 8'(rnd());
        ea = (cmd[3:0] == ifp_pkg::OP_PAGE_ERASE) ? {a[15:7], 7'h00} : a;
        c0 = req_cnt;
        wr(ifp_pkg::ADDR_OP_COMMAND, cmd);
        wr(ifp_pkg::ADDR_TADDR_HIGH, a[15:8]);
        wr(ifp_pkg::ADDR_TADDR_LOW, a[7:0]);
        wr(ifp_pkg::ADDR_FLASH_DATA, fd);
        pw(ifp_pkg::ADDR_TRIGGER, 8'h01);
        repeat (2) @(posedge core_clk);
        #1 chk(16'(req_cnt - c0), {15'h0000, ok});
        if (ok) begin
            chk(core_hold, 1'b1);
            chk(flash_addr, ea);
            chk({flash_region, flash_opcode, flash_wdata}, {cmd[7:6], cmd[3:0], fd});
            n = 0;
            while (core_hold !== 1'b0 && n < 40) begin
                @(posedge core_clk);
                #1 n++;
            end
            chk(n > 2 && n < 40, 1'b1);
            rd(ifp_pkg::ADDR_TRIGGER, r);
            chk(r, 8'h00);
            if (!cmd[5]) begin
                rd(ifp_pkg::ADDR_FLASH_DATA, r);
                chk(r, ea[7:0] ^ ea[15:8] ^ 8'hc3);
            end
        end
        rd(ifp_pkg::ADDR_CHIP_CONTROL, r);
        chk(r, ccr(flt));
        if (flt) begin
            rd(ifp_pkg::ADDR_CHIP_CONTROL, r);
            chk(r, ccr(1'b1));
            pw(ifp_pkg::ADDR_CHIP_CONTROL, ccw(1'b0, 1'b0));
            rd(ifp_pkg::ADDR_CHIP_CONTROL, r);
            chk(r, ccr(1'b0));
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // watchdog well beyond the expected run of under a thousand cycles
    initial begin
        repeat (20000) @(posedge core_clk);
        error_cnt++;
        give_verdict();
    end
    // main sequence
    initial begin
        core_clk = 0; sys_rst = 1; sfr_wr = 0; sfr_rd = 0; sfr_addr = 8'h00;
        sfr_wdata = 8'h00; code_in_loader = 1; boot_strap = 1;
        ldu = 0; en = 0; bootw = 1;
        repeat (20) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        #1 chk(boot_next, 1'b1);
        for (i = 0; i < 7; i++) begin
            rd(ra[i], r);
            chk(r, rv[i]);
        end
        // unprotected write is dropped
        wr(ifp_pkg::ADDR_CHIP_CONTROL, 8'h01);
        rd(ifp_pkg::ADDR_CHIP_CONTROL, r);
        chk(r, ccr(1'b0));
        en = 1;
        bootw = 0;
        pw(ifp_pkg::ADDR_CHIP_CONTROL, ccw(1'b0, 1'b1));
        rd(ifp_pkg::ADDR_CHIP_CONTROL, r);
        chk(r, ccr(1'b0));
        chk({boot_next, rc_osc_enable}, 2'b01);
        // random legal traffic from loader code into application flash
        for (i = 0; i < 9; i++) begin
            r = 8'(i % 3);
            rw = rnd();
            op({2'b00, r != 8'h00, 1'b0, r[3:0]}, {2'b00, rw[13:0]}, 1'b1, 1'b0);
        end
        op(8'h62, 16'h07ff, 1'b0, 1'b1);
        op(8'h00, 16'h4000, 1'b0, 1'b1);
        op(8'hc0, 16'h0003, 1'b1, 1'b0);
        code_in_loader <= 1'b0;
        op(8'h21, 16'h0100, 1'b0, 1'b1);
        op(8'h61, 16'h0010, 1'b0, 1'b1);
        op(8'hc0, 16'h0002, 1'b0, 1'b1);
        rw = rnd();
        op(8'h40, {5'h00, rw[10:0]}, 1'b1, 1'b0);
        ldu = 1;
        pw(ifp_pkg::ADDR_CHIP_CONTROL, ccw(1'b0, 1'b1));
        op(8'h62, 16'h07c5, 1'b1, 1'b0);
        op(8'h61, 16'h0011, 1'b1, 1'b0);
        // disabled engine ignores triggers and stops the oscillator
        en = 0;
        pw(ifp_pkg::ADDR_CHIP_CONTROL, ccw(1'b0, 1'b1));
        repeat (2) @(posedge core_clk);
        #1 chk(rc_osc_enable, 1'b0);
        op(8'h00, 16'h0010, 1'b0, 1'b0);
        i = sr_cnt;
        bootw = 1;
        pw(ifp_pkg::ADDR_CHIP_CONTROL, ccw(1'b1, 1'b1));
        repeat (3) @(posedge core_clk);
        #1 chk(16'(sr_cnt - i), 16'h0001);
        chk(boot_next, 1'b1);
        // mid-run reset with the other boot source strapped
        boot_strap <= 1'b0;
        sys_rst    <= 1'b1;
        repeat (3) @(posedge core_clk);
        sys_rst <= 1'b0;
        ldu = 0;
        @(posedge core_clk);
        #1 chk(boot_next, 1'b0);
        rd(ifp_pkg::ADDR_CHIP_CONTROL, r);
        chk(r, ccr(1'b0));
        give_verdict();
    end
endmodule // test_inapp_flash_program_control
